// >>> adc_converter_model.sv
/* converter model facing the sequencer's conversion port.
   assumes one conversion at a time, started by a one-cycle conv_start. */
module adc_converter_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // conversion request and pace
  input  wire logic        conv_start,
  input  wire logic [3:0]  conv_chan,
  input  wire logic        slow,
  // result
  output logic             conv_done,
  output logic [11:0]      conv_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] left_r;  // cycles left in this conversion
  logic [3:0] chan_r;  // channel latched at start
  // fixed result per channel, so any averaging keeps the value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_r    <= 4'h0;
      chan_r    <= 4'h0;
      conv_done <= 1'b0;
      conv_data <= 12'h0;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;  // bus churns outside done, never a stale match
      if (conv_start) begin
        chan_r <= conv_chan;
        left_r <= slow ? 4'h9 : 4'h2;
      end else if (left_r == 4'h1) begin
        conv_done <= 1'b1;
        conv_data <= {chan_r, 8'h3c};
        left_r    <= 4'h0;
      end else if (left_r != 4'h0) begin
        left_r <= left_r - 4'h1;
      end
    end
  end
endmodule  // adc_converter_model

// >>> adc_sample_sequencer.v
/*
 * adc_sample_sequencer.v - four prioritised sample sequencers with
 * hardware and per-sequencer software averaging, result fifos, and
 * per-sequencer interrupts, behind an apb slave.
 * Assumes a converter that takes conv_start/conv_chan and returns
 * conv_done with conv_data some cycles later; triggers are synchronous.
 */
// What this block does
// - four sequencers, depths eight, four, four, one
// - eight external channels plus temperature sensor
// - every step picks its own channel
// - per-sequencer trigger source, capture only when triggered
// - highest-priority pending sequencer sampled first
// - hardware averaging 2x to 64x, slower throughput
// - one hardware averaging setting for all
// - software averaging 2x/4x/8x per sequencer, shrinks depth
// - disabled sequencer ignores its trigger
// - sticky fifo overflow and underflow flags
// - processor trigger starts addressed processor-triggered sequencer
// - per-sequencer mask, raw, masked status, clear
// - priorities 0..3, 0 highest, equal codes go to the lower sequencer number
// - hardware averaging zero means unaveraged
// - enabling an interrupt clears its pending status
// - continuous trigger recaptures whenever idle
`include "adc_seq_consts.vh"
module adc_sample_sequencer #(
  parameter DW = 12                   // converter result width
) (
  // clock and reset
  input  wire          pclk,
  input  wire          presetn,
  // apb slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  output wire          pready,
  output reg  [31:0]   prdata,
  output wire          pslverr,
  // hardware trigger sources
  input  wire [2:0]    comp_trig,
  input  wire          ext_trig,
  input  wire          timer_trig,
  input  wire [2:0]    pwm_trig,
  // converter
  output reg           conv_start,
  output reg  [3:0]    conv_chan,
  input  wire          conv_done,
  input  wire [DW-1:0] conv_data,
  // interrupt
  output wire          irq
);
  localparam S_IDLE = 3'b001;         // waiting for a trigger
  localparam S_CONV = 3'b010;         // conversion in flight
  localparam S_STEP = 3'b100;         // step result handled

  // software-visible control
  reg  [3:0]    enable_r;             // per-sequencer enable
  reg  [15:0]   trig_sel_r;           // trigger codes
  reg  [7:0]    prio_r;               // two bits each
  reg  [2:0]    hw_avg_r;             // log2 factor, 0 off
  reg  [7:0]    sw_avg_r;             // log2 factor per sequencer
  reg  [3:0]    mask_r;               // interrupt mask
  reg  [3:0]    raw_r;                // interrupt raw status
  reg  [3:0]    oflow_r;              // fifo_overflow_flag
  reg  [3:0]    uflow_r;              // fifo_underflow_flag
  reg  [3:0]    pend_r;               // latched trigger events
  reg  [3:0]    step_chan_r [0:16];   // step channel table
  reg  [16:0]   step_end_r;           // last-step marks
  // fifo storage, flat index: seq0 0-7, seq1 8-11, seq2 12-15, seq3 16
  reg  [DW-1:0] fifo_mem [0:16];
  reg  [3:0]    wp_r [0:3];
  reg  [3:0]    rp_r [0:3];
  reg  [3:0]    cnt_r [0:3];
  // engine
  reg  [2:0]    state_r;
  reg  [1:0]    act_r;                // active sequencer
  reg  [2:0]    step_r;               // step within sequence
  reg  [6:0]    hw_cnt_r;             // hardware samples taken
  reg  [DW+5:0] hw_acc_r;             // hardware sum
  reg  [3:0]    sw_cnt_r;             // software samples in group
  reg  [DW+8:0] sw_acc_r;             // software sum

  function [4:0] base_of;             // fifo/step base per sequencer
    input [1:0] s;
    case (s)
      2'd0:    base_of = 5'd0;
      2'd1:    base_of = 5'd8;
      2'd2:    base_of = 5'd12;
      default: base_of = 5'd16;
    endcase
  endfunction
  function [3:0] depth_of;            // sequencer depth
    input [1:0] s;
    case (s)
      2'd0:    depth_of = 4'd8;
      2'd1:    depth_of = 4'd4;
      2'd2:    depth_of = 4'd4;
      default: depth_of = 4'd1;
    endcase
  endfunction

  wire wr = psel & penable & pwrite;
  wire rd = psel & penable & ~pwrite;
  assign pready  = 1'b1;              // zero wait states
  assign pslverr = 1'b0;
  assign irq     = |(raw_r & mask_r);

  // trigger detection per sequencer
  reg  [3:0] trig_hit;
  integer i;
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      case (trig_sel_r[4*i +: 4])
        `TRIG_PROC:   trig_hit[i] = wr && paddr == `OFS_PROC_TRIG && pwdata[i];
        `TRIG_COMP0:  trig_hit[i] = comp_trig[0];
        `TRIG_COMP1:  trig_hit[i] = comp_trig[1];
        `TRIG_COMP2:  trig_hit[i] = comp_trig[2];
        `TRIG_EXT:    trig_hit[i] = ext_trig;
        `TRIG_TIMER:  trig_hit[i] = timer_trig;
        `TRIG_PWM0:   trig_hit[i] = pwm_trig[0];
        `TRIG_PWM1:   trig_hit[i] = pwm_trig[1];
        `TRIG_PWM2:   trig_hit[i] = pwm_trig[2];
        `TRIG_ALWAYS: trig_hit[i] = 1'b1;
        default:      trig_hit[i] = 1'b0;
      endcase
    end
  end

  // priority pick: lowest priority code among pending
  reg [1:0] pick;
  reg       pick_ok;
  reg [1:0] best_p;
  integer   j;                        // own index, so each process drives its own
  always @* begin
    pick = 2'd0;
    pick_ok = 1'b0;
    best_p = 2'd3;
    for (j = 0; j < 4; j = j + 1) begin
      if (pend_r[j] && (!pick_ok || prio_r[2*j +: 2] < best_p)) begin
        pick = j[1:0];
        pick_ok = 1'b1;
        best_p = prio_r[2*j +: 2];
      end
    end
  end

  // averaging helpers
  wire [6:0] hw_need  = (hw_avg_r == 3'd0) ? 7'd1 : (7'd1 << hw_avg_r);
  wire [DW+5:0] hw_sum = hw_acc_r + {6'd0, conv_data};
  // result from the held sum: conv_data only stands in the done cycle
  wire [DW-1:0] hw_res = hw_acc_r[hw_avg_r +: DW];
  wire [1:0] sw_lg    = sw_avg_r[2*act_r +: 2];
  wire [3:0] sw_need  = 4'd1 << sw_lg;
  wire [DW+8:0] sw_sum = sw_acc_r + {9'd0, hw_res};
  wire [DW-1:0] sw_res = sw_sum[sw_lg +: DW];
  wire [4:0] step_idx = base_of(act_r) + {2'd0, step_r};
  // a step group ends on its mark or at the averaged depth edge
  wire [3:0] last_step = (depth_of(act_r) >> sw_lg) - 4'd1;
  wire       seq_end  = step_end_r[step_idx] | ({1'b0, step_r} >> sw_lg == last_step
                          && sw_cnt_r == sw_need - 4'd1);

  // fifo read side decode
  wire       fifo_rd  = rd && paddr[11:4] == `OFS_FIFO_BASE >> 4 && paddr[3:2] != 2'd0
                        || rd && paddr[11:4] == `OFS_FIFO_BASE >> 4;
  wire [1:0] fifo_sel = paddr[3:2];
  // step table writes: 0x40 upward, step 16 shares the fifo 0 word (fifo is read-only)
  wire [11:0] step_off = paddr - `OFS_STEP_BASE;
  wire        step_hit = paddr >= `OFS_STEP_BASE && paddr <= `OFS_FIFO_BASE;

  // sequencing engine and register writes
  integer k;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= 4'h0; trig_sel_r <= `TRIG_RESET; prio_r <= `PRIO_RESET;
      hw_avg_r <= 3'd0; sw_avg_r <= 8'h00; mask_r <= 4'h0; raw_r <= 4'h0;
      oflow_r <= 4'h0; uflow_r <= 4'h0; pend_r <= 4'h0; step_end_r <= 17'h1ffff;
      state_r <= S_IDLE; act_r <= 2'd0; step_r <= 3'd0; hw_cnt_r <= 7'd0;
      hw_acc_r <= {(DW+6){1'b0}}; sw_cnt_r <= 4'd0; sw_acc_r <= {(DW+9){1'b0}};
      conv_start <= 1'b0; conv_chan <= 4'h0;
      for (k = 0; k < 4; k = k + 1) begin
        wp_r[k] <= 4'd0; rp_r[k] <= 4'd0; cnt_r[k] <= 4'd0;
      end
      for (k = 0; k < 17; k = k + 1) begin
        step_chan_r[k] <= 4'h0;
      end
    end else begin
      conv_start <= 1'b0;
      // register writes (clears first, hardware sets below win)
      if (wr) begin
        case (paddr)
          `OFS_ENABLE:     enable_r <= pwdata[3:0];
          `OFS_RAW_STATUS: raw_r <= raw_r & ~pwdata[3:0];
          `OFS_MASK: begin
            mask_r <= pwdata[3:0];
            raw_r  <= raw_r & ~(pwdata[3:0] & ~mask_r);
          end
          `OFS_UFLOW:      uflow_r <= uflow_r & ~pwdata[3:0];
          `OFS_OFLOW:      oflow_r <= oflow_r & ~pwdata[3:0];
          `OFS_TRIG_SEL:   trig_sel_r <= pwdata[15:0];
          `OFS_PRIORITY:   prio_r <= pwdata[7:0];
          `OFS_HW_AVG:     hw_avg_r <= (pwdata[2:0] > 3'd6) ? 3'd6 : pwdata[2:0];
          `OFS_SW_AVG:     sw_avg_r <= pwdata[7:0];
          default: begin
            if (step_hit) begin
              step_chan_r[step_off[6:2]] <= (pwdata[3:0] > `CH_TEMP) ? `CH_TEMP : pwdata[3:0];
              step_end_r[step_off[6:2]]  <= pwdata[4];
            end
          end
        endcase
      end
      // latch triggers of enabled sequencers only
      pend_r <= pend_r | (trig_hit & enable_r);
      // fifo pops and underflow
      if (fifo_rd) begin
        if (cnt_r[fifo_sel] == 4'd0)
          uflow_r[fifo_sel] <= 1'b1;
        else begin
          rp_r[fifo_sel] <= (rp_r[fifo_sel] == depth_of(fifo_sel) - 4'd1) ? 4'd0 : rp_r[fifo_sel] + 4'd1;
          cnt_r[fifo_sel] <= cnt_r[fifo_sel] - 4'd1;
        end
      end
      case (state_r)
        S_IDLE: begin
          if (pick_ok) begin
            act_r <= pick;
            step_r <= 3'd0;
            pend_r[pick] <= trig_hit[pick] & enable_r[pick] & (trig_sel_r[4*pick +: 4] == `TRIG_ALWAYS);
            conv_chan <= step_chan_r[base_of(pick)];
            conv_start <= 1'b1;
            hw_cnt_r <= 7'd0; hw_acc_r <= {(DW+6){1'b0}};
            sw_cnt_r <= 4'd0; sw_acc_r <= {(DW+9){1'b0}};
            state_r <= S_CONV;
          end
        end
        S_CONV: begin
          if (conv_done) begin
            hw_acc_r <= hw_sum;                                      // taken while data stands
            if (hw_cnt_r + 7'd1 < hw_need) begin
              hw_cnt_r <= hw_cnt_r + 7'd1;
              conv_start <= 1'b1;
            end else
              state_r <= S_STEP;
          end
        end
        S_STEP: begin
          // one fully averaged entry per software group
          hw_cnt_r <= 7'd0;
          hw_acc_r <= {(DW+6){1'b0}};
          if (sw_cnt_r == sw_need - 4'd1) begin
            sw_cnt_r <= 4'd0;
            sw_acc_r <= {(DW+9){1'b0}};
            if (cnt_r[act_r] == depth_of(act_r))
              oflow_r[act_r] <= 1'b1;
            else begin
              fifo_mem[base_of(act_r) + {1'b0, wp_r[act_r]}] <= sw_res;
              wp_r[act_r] <= (wp_r[act_r] == depth_of(act_r) - 4'd1) ? 4'd0 : wp_r[act_r] + 4'd1;
              // a pop on an empty fifo took nothing, so it must not cancel the push
              cnt_r[act_r] <= cnt_r[act_r] + 4'd1 - {3'd0, fifo_rd && fifo_sel == act_r && cnt_r[act_r] != 4'd0};
            end
          end else begin
            sw_cnt_r <= sw_cnt_r + 4'd1;
            sw_acc_r <= sw_sum;
          end
          if (seq_end || {1'b0, step_r} == depth_of(act_r) - 4'd1) begin
            raw_r[act_r] <= 1'b1;
            state_r <= S_IDLE;
          end else begin
            step_r <= step_r + 3'd1;
            conv_chan <= step_chan_r[step_idx + 5'd1];
            conv_start <= 1'b1;
            state_r <= S_CONV;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // read data register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        `OFS_ENABLE:     prdata <= {28'h0, enable_r};
        `OFS_RAW_STATUS: prdata <= {28'h0, raw_r};
        `OFS_MASK:       prdata <= {28'h0, mask_r};
        `OFS_MASKED:     prdata <= {28'h0, raw_r & mask_r};
        `OFS_UFLOW:      prdata <= {28'h0, uflow_r};
        `OFS_OFLOW:      prdata <= {28'h0, oflow_r};
        `OFS_TRIG_SEL:   prdata <= {16'h0, trig_sel_r};
        `OFS_PRIORITY:   prdata <= {24'h0, prio_r};
        `OFS_HW_AVG:     prdata <= {29'h0, hw_avg_r};
        `OFS_SW_AVG:     prdata <= {24'h0, sw_avg_r};
        default: begin
          // empty fifo reads zero, never an unwritten word
          if (paddr[11:4] == `OFS_FIFO_BASE >> 4 && cnt_r[paddr[3:2]] != 4'd0)
            prdata <= {{(32-DW){1'b0}}, fifo_mem[base_of(paddr[3:2]) + {1'b0, rp_r[paddr[3:2]]}]};
          else
            prdata <= 32'h0;
        end
      endcase
    end
  end
endmodule // adc_sample_sequencer

// >>> adc_sample_sequencer_monitor.sv
/* port checker for the sample sequencer.
   assumes pclk only and async active-low presetn. */
module adc_sample_sequencer_monitor (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // triggers, converter, interrupt
  input wire logic [2:0]  comp_trig,
  input wire logic        ext_trig,
  input wire logic        timer_trig,
  input wire logic [2:0]  pwm_trig,
  input wire logic        conv_start,
  input wire logic [3:0]  conv_chan,
  input wire logic        conv_done,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wr_age_r;  // cycles since an apb write
  logic [7:0] ev_age_r;  // cycles since any cause of work
  logic       wr_now;
  logic       ev_now;
  assign wr_now = psel & penable & pwrite;
  assign ev_now = wr_now | conv_done | ext_trig | timer_trig | (|comp_trig) | (|pwm_trig);
  // saturating ages: a long idle never wraps into a false cause
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_age_r <= 8'hff;
      ev_age_r <= 8'hff;
    end else begin
      wr_age_r <= wr_now ? 8'h00 : wr_age_r + {7'h0, wr_age_r != 8'hff};
      ev_age_r <= ev_now ? 8'h00 : ev_age_r + {7'h0, ev_age_r != 8'hff};
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_ready; pready; endproperty
  property p_noerr; !pslverr; endproperty
  property p_pulse; conv_start |=> !conv_start; endproperty
  property p_chan; conv_start |-> conv_chan <= 4'h8; endproperty
  property p_cause; conv_start |-> ev_age_r <= 8'h08; endproperty
  property p_rise; $rose(irq) |-> ev_age_r <= 8'h08; endproperty
  property p_fall; $fell(irq) |-> wr_age_r <= 8'h03; endproperty
  property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_noerr: assert property (p_noerr) else $error("pslverr high");
  a_pulse: assert property (p_pulse) else $error("conv_start longer than a cycle");
  a_chan: assert property (p_chan) else $error("channel out of range");
  a_cause: assert property (p_cause) else $error("conversion without cause");
  a_rise: assert property (p_rise) else $error("irq rose without cause");
  a_fall: assert property (p_fall) else $error("irq fell without write");
  a_hold: assert property (p_hold) else $error("prdata moved outside read setup");
  c_start: cover property (conv_start);
  c_irq: cover property ($rose(irq));
  c_clear: cover property ($fell(irq));
endmodule  // adc_sample_sequencer_monitor
bind adc_sample_sequencer adc_sample_sequencer_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .comp_trig(comp_trig), .ext_trig(ext_trig), .timer_trig(timer_trig), .pwm_trig(pwm_trig),
  .conv_start(conv_start), .conv_chan(conv_chan), .conv_done(conv_done), .irq(irq));

// >>> adc_sample_sequencer_test.sv
/* self-checking bench for the sample sequencer.
   assumes the converter model and the monitor bind are compiled first. */
`include "adc_seq_consts.vh"
module adc_sample_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        ext_trig, slow, conv_start, conv_done;
  logic [11:0] paddr, conv_data;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  conv_chan, c, ch;
  int          n_mismatch, check_count, cyc, k, e;
  int          seed = 32'h0a3d;
  int          exp_ch[$];  // channels expected, in conversion order
  adc_sample_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .comp_trig(3'h0), .ext_trig(ext_trig), .timer_trig(1'b0), .pwm_trig(3'h0), .conv_start(conv_start),
    .conv_chan(conv_chan), .conv_done(conv_done), .conv_data(conv_data), .irq(irq));
  adc_converter_model u_conv (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
    .conv_chan(conv_chan), .slow(slow), .conv_done(conv_done), .conv_data(conv_data));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one apb transfer; idle cycle after it so strobes never re-rise in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  // poll raw status until bit b is set, then confirm all expected starts came
  // own poll counter, so callers' loop indices survive
  task wait_raw(input int b);
    int n;
    q = 32'h0;
    for (n = 0; n < 60 && q[b] !== 1'b1; n++) apb(1'b0, `OFS_RAW_STATUS, 32'h0);
    chk("raw set", 32'h1, {31'h0, q[b]});
    chk("pending starts", 32'h0, exp_ch.size());
  endtask
  // model side: every conversion start against the expected order; hang guard
  always @(posedge pclk) begin
    cyc++;
    if (conv_start === 1'b1 && exp_ch.size() == 0) chk("extra start", 32'h0, 32'h1);
    else if (conv_start === 1'b1) chk("conv_chan", exp_ch.pop_front(), conv_chan);
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim;
    end
  end
  initial begin
    {psel, penable, pwrite, ext_trig, slow} = 5'h0;
    paddr   = 12'h0;
    pwdata  = 32'h0;
    presetn = 1'b0;
    c       = 4'($unsigned($random(seed)) % 9);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("prio", `OFS_PRIORITY, 32'he4);
    rdc("trig", `OFS_TRIG_SEL, 32'h0);
    rdc("unmapped", 12'h0fc, 32'h0);
    // random channel on the four-deep sequencer; disabled first
    apb(1'b1, 12'h070, {27'h0, 1'b1, c});
    apb(1'b1, `OFS_PROC_TRIG, 32'h4);
    repeat (30) @(posedge pclk);
    rdc("raw idle", `OFS_RAW_STATUS, 32'h0);
    apb(1'b1, `OFS_ENABLE, 32'h4);
    exp_ch.push_back(c);
    apb(1'b1, `OFS_PROC_TRIG, 32'h4);
    wait_raw(2);
    rdc("fifo2", 12'h088, {20'h0, c, 8'h3c});
    rdc("fifo2 empty", 12'h088, 32'h0);
    rdc("uflow", `OFS_UFLOW, 32'h4);
    apb(1'b1, `OFS_UFLOW, 32'h4);
    rdc("uflow clr", `OFS_UFLOW, 32'h0);
    // one-deep sequencer captured twice unread
    apb(1'b1, `OFS_ENABLE, 32'hc);
    for (k = 0; k < 2; k++) begin
      exp_ch.push_back(0);
      apb(1'b1, `OFS_PROC_TRIG, 32'h8);
      wait_raw(3);
      apb(1'b1, `OFS_RAW_STATUS, 32'h8);
    end
    rdc("oflow", `OFS_OFLOW, 32'h8);
    apb(1'b1, `OFS_OFLOW, 32'h8);
    rdc("oflow clr", `OFS_OFLOW, 32'h0);
    // simultaneous triggers; seq1 outranks seq0, which walks 5,0,5
    apb(1'b1, 12'h040, 32'h05);
    apb(1'b1, 12'h044, 32'h00);
    apb(1'b1, 12'h048, 32'h15);
    apb(1'b1, 12'h060, 32'h12);
    apb(1'b1, `OFS_PRIORITY, 32'he1);
    apb(1'b1, `OFS_ENABLE, 32'hf);
    exp_ch = {2, 5, 0, 5};
    apb(1'b1, `OFS_PROC_TRIG, 32'h3);
    wait_raw(0);
    rdc("fifo1", 12'h084, 32'h23c);
    rdc("fifo0 a", 12'h080, 32'h53c);
    rdc("fifo0 b", 12'h080, 32'h03c);
    rdc("fifo0 c", 12'h080, 32'h53c);
    // interrupt: clear, enable clears pending, raise, masked view, clear
    apb(1'b1, `OFS_RAW_STATUS, 32'hf);
    rdc("raw clr", `OFS_RAW_STATUS, 32'h0);
    for (k = 0; k < 2; k++) begin
      exp_ch = {5, 0, 5};
      apb(1'b1, `OFS_PROC_TRIG, 32'h1);
      wait_raw(0);
      chk("irq", {31'h0, k == 1}, {31'h0, irq});
      if (k == 0) begin
        apb(1'b1, `OFS_MASK, 32'h1);
        rdc("raw on enable", `OFS_RAW_STATUS, 32'h0);
      end
    end
    rdc("masked", `OFS_MASKED, 32'h1);
    apb(1'b1, `OFS_RAW_STATUS, 32'h1);
    chk("irq clr", 32'h0, {31'h0, irq});
    apb(1'b1, `OFS_MASK, 32'h0);
    // 4x hardware averaging, slow converter, external trigger on seq2
    apb(1'b1, `OFS_RAW_STATUS, 32'hf);
    apb(1'b1, `OFS_HW_AVG, 32'h2);
    apb(1'b1, `OFS_TRIG_SEL, 32'h400);
    slow <= 1'b1;
    repeat (4) exp_ch.push_back(c);
    ext_trig <= 1'b1;
    @(posedge pclk);
    ext_trig <= 1'b0;
    wait_raw(2);
    rdc("fifo2 avg", 12'h088, {20'h0, c, 8'h3c});
    // software 4x on the eight-deep sequencer; old entries drained first
    apb(1'b1, `OFS_HW_AVG, 32'h0);
    apb(1'b1, `OFS_SW_AVG, 32'h2);
    slow <= 1'b0;
    for (k = 0; k < 6; k++) rdc("fifo0 drain", 12'h080, (k % 3 == 1) ? 32'h03c : 32'h53c);
    e = 0;
    for (k = 0; k < 8; k++) begin
      ch = (k < 4) ? c : 4'(k);
      apb(1'b1, 12'(12'h040 + 4 * k), {27'h0, k == 7, ch});
      exp_ch.push_back(ch);
      if (k >= 4) e += {ch, 8'h3c};
    end
    apb(1'b1, `OFS_PROC_TRIG, 32'h1);
    wait_raw(0);
    rdc("avg grp 1", 12'h080, {20'h0, c, 8'h3c});
    rdc("avg grp 2", 12'h080, e / 4);
    rdc("avg depth", 12'h080, 32'h0);
    // continuous trigger on the lowest-priority sequencer recaptures
    for (k = 0; k < 64; k++) exp_ch.push_back(0);
    apb(1'b1, `OFS_TRIG_SEL, 32'hf400);
    repeat (60) @(posedge pclk);
    apb(1'b1, `OFS_ENABLE, 32'h7);
    repeat (20) @(posedge pclk);
    k = exp_ch.size();
    chk("recaptures", 32'h1, {31'h0, k < 60});
    repeat (30) @(posedge pclk);
    chk("quiet after disable", k, exp_ch.size());
    exp_ch.delete();
    end_sim;
  end
endmodule  // adc_sample_sequencer_test

// >>> adc_seq_consts.vh
/*
 * adc_seq_consts.vh - register offsets, reset values
 * and encodings for the sample sequencer block.
 * Assumes inclusion by bare name from a Verilog-2005 design file.
 */
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// register byte offsets (apb, one aligned word each)
`define OFS_ENABLE      12'h000
`define OFS_RAW_STATUS  12'h004
`define OFS_MASK        12'h008
`define OFS_MASKED      12'h00c
`define OFS_UFLOW       12'h010
`define OFS_OFLOW       12'h014
`define OFS_PROC_TRIG   12'h018
`define OFS_TRIG_SEL    12'h01c
`define OFS_PRIORITY    12'h020
`define OFS_HW_AVG      12'h024
`define OFS_SW_AVG      12'h028
`define OFS_STEP_BASE   12'h040
`define OFS_FIFO_BASE   12'h080

// trigger source codes, four bits per sequencer
`define TRIG_PROC       4'h0
`define TRIG_COMP0      4'h1
`define TRIG_COMP1      4'h2
`define TRIG_COMP2      4'h3
`define TRIG_EXT        4'h4
`define TRIG_TIMER      4'h5
`define TRIG_PWM0       4'h6
`define TRIG_PWM1       4'h7
`define TRIG_PWM2       4'h8
`define TRIG_ALWAYS     4'hf

// channel code for the temperature sensor
`define CH_TEMP         4'h8

// reset values
`define PRIO_RESET      8'he4
`define TRIG_RESET      16'h0000

`endif
